// [dwc_pkg.sv]
// constants and types for the ddr ecc write legality check
// assumes a single 50 MHz clock domain and synchronous active-high reset
package dwc_pkg;

	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int STRB_W = DATA_W / 8;
	localparam int INIT_W = 8;
	localparam int NUM_RANGES = 4;
	localparam int TYPE_W = 2;

	// bus width selects the ecc quantum: 16 or 32 bits
	localparam int QUANTUM_16_BYTES = 2;
	localparam int QUANTUM_32_BYTES = 4;

	// reset values
	localparam logic [STRB_W-1:0] STRB_NONE = 4'h0;
	localparam logic [TYPE_W-1:0] TYPE_NONE = 2'h0;
	localparam logic [INIT_W-1:0] INIT_NONE = 8'h00;

	// access type codes stored in the offender log
	typedef enum logic [TYPE_W-1:0] {
		DWC_ACC_READ = 2'h0,
		DWC_ACC_WRITE = 2'h1,
		DWC_ACC_WRITE_BURST = 2'h3
	} dwc_acc_t;

	// response codes toward the initiator
	typedef enum logic [1:0] {
		DWC_RESP_OKAY = 2'h0,
		DWC_RESP_ERROR = 2'h2
	} dwc_resp_t;

	// checker pipeline states, gray along idle -> check -> respond
	typedef enum logic [1:0] {
		DWC_IDLE = 2'b00,
		DWC_CHECK = 2'b01,
		DWC_RESP = 2'b11
	} dwc_state_t;

endpackage : dwc_pkg

// [dwc_region_if.sv]
// carries one request and its region verdict between top and region matcher
// assumes both ends on ref_clk
`timescale 1ns/100ps
interface dwc_region_if;
	import dwc_pkg::*;
	logic [ADDR_W-1:0] addr; // request address
	logic hit; // address lies in an ecc range
	modport top (output addr, input hit);
	modport matcher (input addr, output hit);
endinterface : dwc_region_if

// [dwc_region_match.sv]
// range matcher: decides if an address lies in an enabled ecc range
// assumes range limits held stable by the configuration source
`timescale 1ns/100ps
module dwc_region_match
	import dwc_pkg::*;
(
	dwc_region_if.matcher rif, // address in, verdict out
	input wire logic ecc_enable, // global ecc enable
	input wire logic [NUM_RANGES-1:0] range_enable, // per-range enable
	input wire logic [NUM_RANGES*ADDR_W-1:0] range_base, // packed bases
	input wire logic [NUM_RANGES*ADDR_W-1:0] range_limit // packed limits
);
	// only enabled ranges protect; global disable clears everything
	always_comb begin
		rif.hit = 1'b0;
		for (int i = 0; i < NUM_RANGES; i++) begin
			if (ecc_enable && range_enable[i] &&
					rif.addr >= range_base[i*ADDR_W +: ADDR_W] &&
					rif.addr <= range_limit[i*ADDR_W +: ADDR_W]) begin
				rif.hit = 1'b1;
			end
		end
	end
endmodule : dwc_region_match

// [dwc_ecc_write_check.sv]
// write legality checker for a ddr controller with ecc regions
// assumes initiators hold a request until accepted, one in flight at a time
`timescale 1ns/100ps

// Functional notes
// - in ecc range, a legal write is whole-quantum sized and aligned
// - any sub-quantum write into ecc space is flagged illegal
// - an illegal ecc write raises the error interrupt pulse
// - the offending initiator gets an error response for that write
// - legal traffic never receives an error response
// - error interrupt never fires for legal traffic
// - type and initiator of the latest offender are logged, overwriting
// - ecc may be enabled per range or disabled globally
module dwc_ecc_write_check
	import dwc_pkg::*;
(
	// clock and reset
	input wire logic ref_clk, // 50 MHz clock
	input wire logic reset, // synchronous, active high
	// configuration, to be held still while traffic flows
	input wire logic bus_is_32, // 1: 32-bit ddr bus, 0: 16-bit
	input wire logic ecc_enable, // global ecc enable
	input wire logic [dwc_pkg::NUM_RANGES-1:0] range_enable, // per range
	input wire logic [dwc_pkg::NUM_RANGES*dwc_pkg::ADDR_W-1:0] range_base, // lo
	input wire logic [dwc_pkg::NUM_RANGES*dwc_pkg::ADDR_W-1:0] range_limit, // hi
	// request side, from the on-chip initiators
	input wire logic req_valid, // request present
	output logic req_ready, // request taken this cycle
	input wire logic req_write, // 1 write, 0 read
	input wire logic req_burst, // write is part of a burst
	input wire logic [dwc_pkg::ADDR_W-1:0] req_addr, // byte address
	input wire logic [dwc_pkg::STRB_W-1:0] req_strb, // byte enables
	input wire logic [dwc_pkg::INIT_W-1:0] req_init, // initiator id
	// answer back to the initiator
	output logic resp_valid, // response pulse
	output logic [1:0] resp_code, // okay or error
	output logic [dwc_pkg::INIT_W-1:0] resp_init, // initiator addressed
	// legal traffic toward the ddr side
	output logic fwd_valid, // legal access forwarded to ddr pulse
	output logic [dwc_pkg::ADDR_W-1:0] fwd_addr, // forwarded address
	output logic [dwc_pkg::STRB_W-1:0] fwd_strb, // forwarded byte enables
	output logic fwd_write, // forwarded direction
	// interrupt and offender log
	output logic err_irq, // error interrupt pulse to cpu
	output logic [dwc_pkg::TYPE_W-1:0] log_type, // last offender access type
	output logic [dwc_pkg::INIT_W-1:0] log_init, // last offender initiator
	output logic log_valid // log holds a record
);
	import dwc_pkg::*;

	dwc_state_t state;
	logic [ADDR_W-1:0] cap_addr;
	logic [STRB_W-1:0] cap_strb;
	logic [INIT_W-1:0] cap_init;
	logic cap_write;
	logic cap_burst;
	logic in_ecc;
	logic illegal;
	logic take; // request accepted at this edge
	logic judge; // captured request is being judged
	logic [TYPE_W-1:0] next_log_type; // kind of the current offender

	// matcher works on the captured address, never the live one
	dwc_region_if rif ();
	assign rif.addr = cap_addr;

	dwc_region_match u_match (
		.rif(rif),
		.ecc_enable(ecc_enable),
		.range_enable(range_enable),
		.range_base(range_base),
		.range_limit(range_limit)
	);
	assign in_ecc = rif.hit;

	// accept only from idle; ready is low there, so one capture per request
	assign take = (state == DWC_IDLE) && req_valid && !req_ready;

	// the verdict is formed in the single check cycle
	assign judge = (state == DWC_CHECK);

	// burst writes are logged apart so software can tell them from singles
	always_comb begin
		next_log_type = DWC_ACC_WRITE;
		if (cap_burst) begin
			next_log_type = DWC_ACC_WRITE_BURST;
		end
	end

	// whole-quantum aligned test; a 16-bit bus uses strobe lanes 1:0 only
	function automatic logic quantum_ok(
			input logic is32,
			input logic [ADDR_W-1:0] a,
			input logic [STRB_W-1:0] s);
		logic ok;
		ok = 1'b0;
		if (is32) begin
			ok = (a[1:0] == 2'h0) && (s == 4'hf);
		end else begin
			ok = (a[0] == 1'b0) && (s[1:0] == 2'h3);
		end
		return ok;
	endfunction : quantum_ok

	// reads are never illegal; only sub-quantum or unaligned writes in ecc space are
	// so an unaligned read in ecc space is let through untouched
	assign illegal = cap_write && in_ecc &&
		!quantum_ok(bus_is_32, cap_addr, cap_strb);

	// state sequence: capture, check one cycle, answer one cycle
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state <= DWC_IDLE;
		end else begin
			case (state)
				DWC_IDLE: begin
					if (take) begin
						state <= DWC_CHECK;
					end
				end
				DWC_CHECK: begin
					state <= DWC_RESP; // verdict is registered here
				end
				DWC_RESP: begin
					state <= DWC_IDLE; // answer pulse, then free again
				end
				default: begin
					state <= DWC_IDLE; // unused code falls back to idle
				end
			endcase
		end
	end

	// request capture; ready is a one-cycle accept pulse
	// config is not captured, so it must stay put while a request is busy
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			req_ready <= 1'b0;
			cap_addr <= '0;
			cap_strb <= STRB_NONE;
			cap_init <= INIT_NONE;
			cap_write <= 1'b0;
			cap_burst <= 1'b0;
		end else begin
			req_ready <= 1'b0;
			if (take) begin
				req_ready <= 1'b1;
				cap_addr <= req_addr;
				cap_strb <= req_strb;
				cap_init <= req_init;
				cap_write <= req_write;
				cap_burst <= req_burst;
			end
		end
	end

	// response to initiator; the verdict comes from the captured request only,
	// so no other queued command can corrupt it
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			resp_valid <= 1'b0;
			resp_code <= DWC_RESP_OKAY;
			resp_init <= INIT_NONE;
		end else begin
			resp_valid <= 1'b0;
			if (judge) begin
				resp_valid <= 1'b1;
				resp_init <= cap_init;
				if (illegal) begin
					resp_code <= DWC_RESP_ERROR;
				end else begin
					resp_code <= DWC_RESP_OKAY;
				end
			end
		end
	end

	// legal accesses pass on to the ddr side; illegal writes are dropped
	// dropping them keeps memory and its ecc bits clear of bad writes
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			fwd_valid <= 1'b0;
			fwd_addr <= '0;
			fwd_strb <= STRB_NONE;
			fwd_write <= 1'b0;
		end else begin
			fwd_valid <= 1'b0;
			if (judge && !illegal) begin
				fwd_valid <= 1'b1;
				fwd_addr <= cap_addr;
				fwd_strb <= cap_strb;
				fwd_write <= cap_write;
			end
		end
	end

	// interrupt pulse only on a true illegal write
	// registered, so the cpu never sees a glitch from the range compare
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			err_irq <= 1'b0;
		end else begin
			err_irq <= judge && illegal;
		end
	end

	// offender log, latest wins; untouched by legal traffic
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			log_type <= TYPE_NONE;
			log_init <= INIT_NONE;
			log_valid <= 1'b0;
		end else if (judge && illegal) begin
			log_type <= next_log_type;
			log_init <= cap_init;
			log_valid <= 1'b1;
		end
	end

endmodule : dwc_ecc_write_check

// [dwc_chk_asserts.sv]
// port assertions for the ecc write legality checker
// assumes a bind to dwc_ecc_write_check, one ref_clk domain
`timescale 1ns/100ps
module dwc_chk_asserts
	import dwc_pkg::*;
(
	input wire logic ref_clk, // clock
	input wire logic reset, // sync reset
	input wire logic bus_is_32, // wide bus
	input wire logic req_ready, // accept
	input wire logic req_write, // write
	input wire logic [dwc_pkg::ADDR_W-1:0] req_addr, // address
	input wire logic [dwc_pkg::STRB_W-1:0] req_strb, // strobes
	input wire logic [dwc_pkg::INIT_W-1:0] req_init, // id
	input wire logic resp_valid, // answer
	input wire logic [1:0] resp_code, // code
	input wire logic [dwc_pkg::INIT_W-1:0] resp_init, // target
	input wire logic fwd_valid, // forwarded
	input wire logic err_irq, // interrupt
	input wire logic [dwc_pkg::INIT_W-1:0] log_init, // offender
	input wire logic log_valid // record
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (reset);
	a_irq_err_resp: assert property (
		err_irq |-> resp_valid && resp_code == 2'h2)
		else $error("irq without error answer");
	a_fwd_okay: assert property (
		fwd_valid |-> resp_valid && resp_code == 2'h0)
		else $error("forward without okay");
	a_one_verdict: assert property (
		resp_valid |-> err_irq != fwd_valid)
		else $error("answer not exactly one verdict");
	// fields drop once ready shows, so they are read back at the taking edge
	a_resp_timing: assert property (
		$rose(req_ready) |-> ##1 resp_valid && resp_init == $past(req_init, 2))
		else $error("answer late or to wrong id");
	a_read_okay: assert property (
		$rose(req_ready) && !$past(req_write)
		|-> ##1 resp_code == 2'h0 && !err_irq)
		else $error("read answered with error");
	a_legal_wide: assert property (
		$rose(req_ready) && $past(req_write) && bus_is_32 && $past(req_strb) == 4'hf
		&& $past(req_addr[1:0]) == 2'h0 |-> ##1 fwd_valid)
		else $error("whole aligned word not forwarded");
	a_log_hold: assert property (
		!err_irq |-> $stable(log_init))
		else $error("log moved without offender");
	a_log_update: assert property (
		err_irq |-> log_valid && log_init == resp_init)
		else $error("log missed offender");
endmodule : dwc_chk_asserts

// [dwc_initiator.sv]
// bus initiator model: one request at a time, held until accepted
// assumes the checker answers within a few ref_clk cycles
`timescale 1ns/100ps
module dwc_initiator
	import dwc_pkg::*;
(
	input wire logic ref_clk, // clock
	input wire logic req_ready, // accept
	input wire logic resp_valid, // answer
	output logic req_valid, // request
	output logic req_write, // direction
	output logic [dwc_pkg::ADDR_W-1:0] req_addr, // address
	output logic [dwc_pkg::STRB_W-1:0] req_strb, // strobes
	output logic [dwc_pkg::INIT_W-1:0] req_init // id
);
	initial begin
		{req_valid, req_write, req_addr, req_strb, req_init} = '0;
	end
	// fields invert on release so a stale value can never match
	task issue(input logic w, input logic [31:0] a, input logic [3:0] s,
		input logic [7:0] id);
		int n;
		n = 0;
		@(posedge ref_clk);
		#1;
		{req_valid, req_write, req_addr, req_strb, req_init} = {1'b1, w, a, s, id};
		do begin
			@(posedge ref_clk);
			#1;
			n++;
		end while (!req_ready && n < 8);
		req_valid = 1'b0;
		{req_write, req_addr, req_strb, req_init} = ~{w, a, s, id};
		while (!resp_valid && n < 16) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
	endtask : issue
endmodule : dwc_initiator

// [dwc_ecc_write_check_tb.sv]
// testbench for the ecc write legality checker
// assumes range 0 covers 0x1000..0x1fff, burst flag driven as a level
`timescale 1ns/100ps
module dwc_ecc_write_check_tb;
	import dwc_pkg::*;
	logic ref_clk, reset, bus_is_32, ecc_enable, req_valid, req_ready;
	logic req_write, resp_valid, fwd_valid, fwd_write, err_irq, log_valid;
	logic [3:0] range_enable, req_strb, fwd_strb;
	logic [127:0] range_base = {4{32'h1000}}, range_limit = {4{32'h1fff}};
	logic [31:0] req_addr, fwd_addr;
	logic [7:0] req_init, resp_init, log_init, exp_init = 8'h00;
	logic [1:0] resp_code, log_type, exp_type = 2'h0;
	logic req_burst = 1'b0, exp_lv = 1'b0;
	int n_fail = 0, checks = 0, cycles = 0;
	dwc_ecc_write_check dut (.*);
	dwc_initiator ini (.*);
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// hang guard, far above the ~40 cycles the run needs
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 2000) begin
			n_fail++;
			close_out();
		end
	end
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// one transfer, judged in the cycle its answer pulses
	task run(input logic w, input logic [31:0] a, input logic [3:0] s,
		input logic [7:0] id, input logic bad);
		ini.issue(w, a, s, id);
		if (bad) begin
			exp_init = id;
			exp_type = req_burst ? DWC_ACC_WRITE_BURST : DWC_ACC_WRITE;
			exp_lv = 1'b1;
		end
		chk("resp_valid", 32'(resp_valid), 32'h1);
		chk("err_irq", 32'(err_irq), 32'(bad));
		chk("fwd_valid", 32'(fwd_valid), 32'(!bad));
		chk("resp_code", 32'(resp_code), bad ? 32'h2 : 32'h0);
		chk("resp_init", 32'(resp_init), 32'(id));
		chk("log_init", 32'(log_init), 32'(exp_init));
		chk("log_type", 32'(log_type), 32'(exp_type));
		chk("log_valid", 32'(log_valid), 32'(exp_lv));
		// forwarded fields only mean something for legal traffic
		if (!bad) begin
			chk("fwd_addr", fwd_addr, a);
			chk("fwd_strb", 32'(fwd_strb), 32'(s));
			chk("fwd_write", 32'(fwd_write), 32'(w));
		end
	endtask : run
	task t_wide;
		bus_is_32 = 1'b1;
		run(1'b1, 32'h1000, 4'hf, 8'h11, 1'b0);
		run(1'b1, 32'h1002, 4'hf, 8'h12, 1'b1);
		run(1'b1, 32'h1ffc, 4'h3, 8'h13, 1'b1);
		run(1'b0, 32'h1001, 4'h1, 8'h14, 1'b0);
	endtask : t_wide
	task t_narrow;
		bus_is_32 = 1'b0;
		run(1'b1, 32'h1002, 4'h3, 8'h21, 1'b0);
		run(1'b1, 32'h1001, 4'h3, 8'h22, 1'b1);
		run(1'b1, 32'h1000, 4'h2, 8'h23, 1'b1);
	endtask : t_narrow
	// burst writes: offender logged as burst, legal burst keeps the log
	task t_burst;
		bus_is_32 = 1'b1;
		req_burst = 1'b1;
		run(1'b1, 32'h1004, 4'hc, 8'h41, 1'b1);
		run(1'b1, 32'h1008, 4'hf, 8'h42, 1'b0);
		req_burst = 1'b0;
	endtask : t_burst
	task t_ranges;
		bus_is_32 = 1'b1;
		run(1'b1, 32'h2000, 4'h1, 8'h31, 1'b0);
		range_enable = 4'h0;
		run(1'b1, 32'h1000, 4'h1, 8'h32, 1'b0);
		range_enable = 4'h1;
		ecc_enable = 1'b0;
		run(1'b1, 32'h1000, 4'h1, 8'h33, 1'b0);
	endtask : t_ranges
	task close_out;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out
	initial begin
		{reset, bus_is_32, ecc_enable, range_enable} = 7'h71;
		repeat (2) @(posedge ref_clk);
		#1;
		reset = 1'b0;
		t_wide();
		t_narrow();
		t_burst();
		t_ranges();
		close_out();
	end
endmodule : dwc_ecc_write_check_tb
bind dwc_ecc_write_check dwc_chk_asserts u_chk (.ref_clk, .reset, .bus_is_32,
	.req_ready, .req_write, .req_addr, .req_strb, .req_init, .resp_valid,
	.resp_code, .resp_init, .fwd_valid, .err_irq, .log_init, .log_valid);
